// >>> prs_pkg.sv
// package: register map, field layouts and carriers for the page/status bank
package prs_pkg;

	// ****************************************
	// register map (offset within a page)
	// ****************************************
	localparam logic [6:0] OFS_PAGE_CTRL = 7'h00;
	localparam logic [6:0] OFS_SUPERVISOR = 7'h01;
	localparam logic [6:0] OFS_INPUT_LOW = 7'h02;

	// ****************************************
	// page field encodings
	// ****************************************
	localparam logic [2:0] PAGE_ZERO = 3'h0;
	localparam logic [2:0] PAGE_ONE = 3'h1;
	localparam logic [2:0] PAGE_TWO = 3'h2;
	localparam logic [2:0] PAGE_TEST = 3'h3;

	// last mapped offset of pages zero to two; each of them starts at offset zero
	localparam logic [6:0] PAGE0_LAST = 7'h3f;
	localparam logic [6:0] PAGE1_LAST = 7'h4f;
	localparam logic [6:0] PAGE2_LAST = 7'h3f;

	localparam logic [7:0] READ_ZERO = 8'h00;
	localparam logic [6:0] PTR_STEP = 7'h01;
	localparam logic [3:0] RSVD_NIBBLE = 4'h0;

	// write mode encodings
	localparam logic WMODE_PAGE = 1'b0;
	localparam logic WMODE_REPEAT = 1'b1;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic auto_page_return;
		logic write_mode;
		logic [2:0] rsvd;
		logic [2:0] page;
	} prs_ctrl_type;

	localparam prs_ctrl_type CTRL_RESET = '{1'b0, WMODE_PAGE, 3'h0, PAGE_ZERO};

	typedef struct packed {
		logic comparator_1v2_out;
		logic voltage_ramp_active;
		logic charger_wake_input;
		logic power_key_n;
		logic [7:0] input_pin_level;
	} prs_mon_type;

	localparam prs_mon_type MON_RESET = '{1'b0, 1'b0, 1'b0, 1'b1, 8'h00};

endpackage : prs_pkg

// >>> prs_regs.sv
// module: page control copy and live status readout of the control interface
// ****************************************
// Behaviour
// R01: with auto_page_return set, the page field goes back to page zero when the access ends.
// R02: write_mode 0 gives page writes (address steps), 1 gives repeated address/data pairs.
// R03: page 000, 001 and 010 map their own address ranges, 011 is reserved and reads zero.
// R04: page_select_control answers at offset zero of pages 000, 001 and 010, so 0x00, 0x80 and 0x100.
// R05: the serial interface keeps its own page_select_control copy and decodes with it.
// R06: a status read returns the monitored signals as they stand at that read.
// R07: every status bit except supervisor_signal_levels bit 0 has the polarity of the signal it mirrors.
// R08: supervisor_signal_levels bit 3 shows the 1.2 V comparator output.
// R09: supervisor_signal_levels bit 2 is high while any supply is still ramping.
// R10: supervisor_signal_levels bit 0 is high while the power key is held low.
// R11: supervisor_signal_levels bits 7 to 4 carry no signal.
// R12: writes to status registers change nothing and reserved bits read zero; the page control rsvd bits 5 to 3 are stored and read back as written.
// R13: the host clears event registers by writing back the value it read.
// ****************************************
`timescale 1ns/10ps
module prs_regs (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wr_valid,
	input wire logic wr_first,
	input wire logic [7:0] wr_byte,
	input wire logic rd_req,
	input wire logic xfer_end,
	input wire logic comparator_1v2_out,
	input wire logic voltage_ramp_active,
	input wire logic charger_wake_input,
	input wire logic power_key_n,
	input wire logic [7:0] input_pin_level,
	output logic [7:0] rd_data_q,
	output logic rd_valid_q,
	output prs_pkg::prs_ctrl_type page_ctrl_q
);

	// ****************************************
	// monitor synchronisers
	// ****************************************
	prs_pkg::prs_mon_type mon_meta_q;
	prs_pkg::prs_mon_type mon_q;
	prs_pkg::prs_mon_type mon_raw;

	assign mon_raw = '{comparator_1v2_out, voltage_ramp_active,
		charger_wake_input, power_key_n, input_pin_level};

	// pins are asynchronous to clk; two stages before any read
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mon_meta_q <= prs_pkg::MON_RESET;
			mon_q <= prs_pkg::MON_RESET;
		end else begin
			mon_meta_q <= mon_raw;
			mon_q <= mon_meta_q;
		end
	end

	// ****************************************
	// address decode
	// ****************************************
	logic [6:0] ptr_q;
	logic [6:0] ptr_d;
	logic expect_addr_q;
	logic expect_addr_d;
	logic data_wr;
	logic addr_wr;
	logic mapped;
	logic ctrl_hit;
	logic [7:0] status_a;
	logic [7:0] status_b;
	logic [7:0] rd_mux;

	// repeated mode: every data byte is followed by a fresh address
	assign addr_wr = wr_valid && (wr_first ||
		(page_ctrl_q.write_mode == prs_pkg::WMODE_REPEAT && expect_addr_q)); // R02
	assign data_wr = wr_valid && !addr_wr;

	// decode uses only this interface's own copy of the page field
	always_comb begin
		case (page_ctrl_q.page) // R05
			prs_pkg::PAGE_ZERO: mapped = ptr_q <= prs_pkg::PAGE0_LAST; // R03
			prs_pkg::PAGE_ONE: mapped = ptr_q <= prs_pkg::PAGE1_LAST; // R03
			prs_pkg::PAGE_TWO: mapped = ptr_q <= prs_pkg::PAGE2_LAST; // R03
			default: mapped = 1'b0; // R03
		endcase
	end

	assign ctrl_hit = mapped && ptr_q == prs_pkg::OFS_PAGE_CTRL; // R04

	// live values, no history kept; polarity as at the pin except the inverted power key bit
	assign status_a = {prs_pkg::RSVD_NIBBLE, // R11 R12
		mon_q.comparator_1v2_out, // R08 R07
		mon_q.voltage_ramp_active, // R09
		mon_q.charger_wake_input,
		!mon_q.power_key_n}; // R10
	assign status_b = mon_q.input_pin_level; // R06 R07

	// event, fault and mask registers live elsewhere; they read zero here
	always_comb begin
		rd_mux = prs_pkg::READ_ZERO;
		if (ctrl_hit) begin
			rd_mux = page_ctrl_q; // R04
		end else if (mapped && page_ctrl_q.page == prs_pkg::PAGE_ZERO) begin
			if (ptr_q == prs_pkg::OFS_SUPERVISOR) begin
				rd_mux = status_a; // R06
			end else if (ptr_q == prs_pkg::OFS_INPUT_LOW) begin
				rd_mux = status_b; // R06
			end
		end
	end

	// ****************************************
	// pointer and write sequencing
	// ****************************************
	always_comb begin
		ptr_d = ptr_q;
		expect_addr_d = expect_addr_q;
		if (addr_wr) begin
			ptr_d = wr_byte[6:0];
			expect_addr_d = 1'b0;
		end else if (data_wr) begin
			if (page_ctrl_q.write_mode == prs_pkg::WMODE_REPEAT) begin
				expect_addr_d = 1'b1; // R02
			end else begin
				ptr_d = ptr_q + prs_pkg::PTR_STEP; // R02
			end
		end else if (rd_req) begin
			ptr_d = ptr_q + prs_pkg::PTR_STEP;
		end
		if (xfer_end) begin
			expect_addr_d = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ptr_q <= prs_pkg::OFS_PAGE_CTRL;
			expect_addr_q <= 1'b0;
		end else begin
			ptr_q <= ptr_d;
			expect_addr_q <= expect_addr_d;
		end
	end

	// ****************************************
	// page control copy
	// ****************************************
	prs_pkg::prs_ctrl_type ctrl_d;

	// status writes fall through: nothing is stored for them
	always_comb begin
		ctrl_d = page_ctrl_q;
		if (data_wr && ctrl_hit) begin
			ctrl_d = wr_byte; // R04 R12
		end
		if (xfer_end && ctrl_d.auto_page_return) begin
			ctrl_d.page = prs_pkg::PAGE_ZERO; // R01
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			page_ctrl_q <= prs_pkg::CTRL_RESET;
		end else begin
			page_ctrl_q <= ctrl_d;
		end
	end

	// ****************************************
	// read answer
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rd_data_q <= prs_pkg::READ_ZERO;
			rd_valid_q <= 1'b0;
		end else begin
			rd_valid_q <= rd_req;
			if (rd_req) begin
				rd_data_q <= rd_mux; // R06
			end
		end
	end

	// ****************************************
	// checks
	// ****************************************
	AST_AUTO_PAGE_RETURN: assert property (@(posedge clk) disable iff (!rst_n) // R01
		xfer_end && page_ctrl_q.auto_page_return && !wr_valid
		|=> page_ctrl_q.page == prs_pkg::PAGE_ZERO)
		else $error("page not returned to zero at access end");

	AST_PAGE_WRITE_STEP: assert property (@(posedge clk) disable iff (!rst_n) // R02
		data_wr && page_ctrl_q.write_mode == prs_pkg::WMODE_PAGE
		|=> ptr_q == $past(ptr_q) + prs_pkg::PTR_STEP)
		else $error("page write did not step the pointer");

	AST_REPEAT_ADDR: assert property (@(posedge clk) disable iff (!rst_n) // R02
		data_wr && !xfer_end && page_ctrl_q.write_mode == prs_pkg::WMODE_REPEAT
		##1 !wr_valid && !xfer_end
		##1 wr_valid && !wr_first && !xfer_end
		&& page_ctrl_q.write_mode == prs_pkg::WMODE_REPEAT
		|=> ptr_q == $past(wr_byte[6:0]))
		else $error("repeated write did not take a new address");

	AST_TEST_PAGE_ZERO: assert property (@(posedge clk) disable iff (!rst_n) // R03
		rd_req && page_ctrl_q.page == prs_pkg::PAGE_TEST
		|=> rd_valid_q && rd_data_q == prs_pkg::READ_ZERO)
		else $error("reserved page did not read zero");

	AST_CTRL_MIRROR: assert property (@(posedge clk) disable iff (!rst_n) // R04
		rd_req && ptr_q == prs_pkg::OFS_PAGE_CTRL
		&& page_ctrl_q.page <= prs_pkg::PAGE_TWO
		|=> rd_data_q == $past(page_ctrl_q))
		else $error("page control not visible at offset zero");

	AST_STATUS_LIVE: assert property (@(posedge clk) disable iff (!rst_n) // R08
		rd_req && page_ctrl_q.page == prs_pkg::PAGE_ZERO
		&& ptr_q == prs_pkg::OFS_SUPERVISOR
		|=> rd_data_q[3] == $past(mon_q.comparator_1v2_out)
		&& rd_data_q[2] == $past(mon_q.voltage_ramp_active))
		else $error("status does not follow comparator or ramp");

	AST_KEY_POLARITY: assert property (@(posedge clk) disable iff (!rst_n) // R10
		rd_req && page_ctrl_q.page == prs_pkg::PAGE_ZERO
		&& ptr_q == prs_pkg::OFS_SUPERVISOR
		|=> rd_data_q[0] == !$past(mon_q.power_key_n)
		&& rd_data_q[7:4] == prs_pkg::RSVD_NIBBLE)
		else $error("key bit or reserved bits wrong");

	AST_PIN_LEVELS: assert property (@(posedge clk) disable iff (!rst_n) // R06
		rd_req && page_ctrl_q.page == prs_pkg::PAGE_ZERO
		&& ptr_q == prs_pkg::OFS_INPUT_LOW
		|=> rd_data_q == $past(mon_q.input_pin_level))
		else $error("pin levels not read live");

	AST_STATUS_RO: assert property (@(posedge clk) disable iff (!rst_n) // R12
		data_wr && !xfer_end && ptr_q == prs_pkg::OFS_SUPERVISOR
		|=> page_ctrl_q == $past(page_ctrl_q))
		else $error("status write changed control state");

endmodule : prs_regs

// >>> prs_host.sv
// host model: serial engine strobes toward prs_regs
`timescale 1ns/10ps
module prs_host (
	input wire logic clk,
	output logic wr_valid,
	output logic wr_first,
	output logic [7:0] wr_byte,
	output logic rd_req,
	output logic xfer_end,
	input wire logic [7:0] rd_data_q,
	input wire logic rd_valid_q
);
	initial begin
		wr_valid = 1'b0;
		wr_first = 1'b0;
		wr_byte = 8'h00;
		rd_req = 1'b0;
		xfer_end = 1'b0;
	end
	// one pulse per byte; idle bus inverted so stale data never matches
	task send(input logic [7:0] b, input logic first, input logic last);
		@(posedge clk);
		wr_valid <= 1'b1;
		wr_first <= first;
		wr_byte <= b;
		xfer_end <= last;
		@(posedge clk);
		wr_valid <= 1'b0;
		wr_first <= 1'b0;
		wr_byte <= ~b;
		xfer_end <= 1'b0;
	endtask : send
	// access end with no byte, as after a read
	task stop;
		@(posedge clk);
		xfer_end <= 1'b1;
		@(posedge clk);
		xfer_end <= 1'b0;
	endtask : stop
	// address then one read; no answer gives x
	task rd(input logic [7:0] a, output logic [7:0] d);
		send(a, 1'b1, 1'b0);
		rd_req <= 1'b1;
		@(posedge clk);
		rd_req <= 1'b0;
		#1;
		d = (rd_valid_q === 1'b1) ? rd_data_q : 8'hxx;
	endtask : rd
endmodule : prs_host

// >>> prs_regs_test.sv
// self-checking bench for prs_regs
`timescale 1ns/10ps
module prs_regs_test;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic comp = 1'b0;
	logic ramp = 1'b0;
	logic wake = 1'b0;
	logic key_n = 1'b1;
	logic [7:0] pins = 8'h00;
	logic wr_valid, wr_first, rd_req, xfer_end, rd_valid_q;
	logic [7:0] wr_byte, rd_data_q, d;
	prs_pkg::prs_ctrl_type page_ctrl_q;
	int mismatches = 0;
	int num_checks = 0;
	int cycles = 0;
	always #50 clk = ~clk;
	prs_host HOST (.clk(clk), .wr_valid(wr_valid), .wr_first(wr_first),
		.wr_byte(wr_byte), .rd_req(rd_req), .xfer_end(xfer_end),
		.rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q));
	prs_regs DUT (.clk(clk), .rst_n(rst_n), .wr_valid(wr_valid),
		.wr_first(wr_first), .wr_byte(wr_byte), .rd_req(rd_req),
		.xfer_end(xfer_end), .comparator_1v2_out(comp),
		.voltage_ramp_active(ramp), .charger_wake_input(wake),
		.power_key_n(key_n), .input_pin_level(pins),
		.rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
		.page_ctrl_q(page_ctrl_q));
	// ****************************************
	// helpers
	// ****************************************
	task complete_run;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : complete_run
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task wr(input logic [7:0] v);
		HOST.send(8'h00, 1'b1, 1'b0);
		HOST.send(v, 1'b0, 1'b1);
		@(posedge clk);
		#1;
	endtask : wr
	// page mode walks 01..03, repeat mode lands 0x42 on offset 0
	task pair_seq;
		HOST.send(8'h01, 1'b1, 1'b0);
		HOST.send(8'haa, 1'b0, 1'b0);
		HOST.send(8'h00, 1'b0, 1'b0);
		HOST.send(8'h42, 1'b0, 1'b1);
		@(posedge clk);
		#1;
	endtask : pair_seq
	// hang guard, runs need well under 2000 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			mismatches++;
			complete_run();
		end
	end
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk("ctrl reset", 8'h00, page_ctrl_q);
		pair_seq();
		chk("page mode", 8'h00, page_ctrl_q);
		wr(8'h40);
		pair_seq();
		chk("repeat mode", 8'h42, page_ctrl_q);
		HOST.rd(8'h00, d);
		chk("ctrl 0x100", 8'h42, d);
		@(posedge clk);
		#1;
		chk("read pulse", 8'h00, {7'h00, rd_valid_q});
		wr(8'h01);
		HOST.rd(8'h00, d);
		chk("ctrl 0x80", 8'h01, d);
		HOST.rd(8'h01, d);
		chk("page1 0x81", 8'h00, d);
		wr(8'h81);
		chk("auto_page_return", 8'h80, page_ctrl_q);
		HOST.send(8'h00, 1'b1, 1'b0);
		HOST.send(8'h81, 1'b0, 1'b0);
		HOST.rd(8'h00, d);
		chk("ctrl held", 8'h81, d);
		HOST.stop();
		@(posedge clk);
		#1;
		chk("auto_page_return after read", 8'h80, page_ctrl_q);
		for (int i = 0; i < 2; i++) begin
			logic b;
			b = (i == 0);
			@(posedge clk);
			comp <= b;
			ramp <= ~b;
			wake <= b;
			key_n <= ~b;
			pins <= b ? 8'h5a : 8'ha5;
			HOST.rd(8'h01, d);
			chk("status a", {4'h0, b, ~b, b, b}, d);
			HOST.rd(8'h02, d);
			chk("status b", b ? 8'h5a : 8'ha5, d);
		end
		HOST.rd(8'h01, d);
		HOST.send(8'h01, 1'b1, 1'b0);
		HOST.send(d, 1'b0, 1'b1);
		HOST.rd(8'h01, d);
		chk("status kept", 8'h04, d);
		chk("ctrl kept", 8'h80, page_ctrl_q);
		wr(8'h03);
		HOST.rd(8'h01, d);
		chk("page3", 8'h00, d);
		complete_run();
	end
endmodule : prs_regs_test
